// ---- design/fmmp_flash_map.sv ----
// Flash memory map, partition boundary and page-erase range logic
// Notes on behaviour
// - An erase clears exactly one aligned 128-byte page, nothing else.
// - Booting from application flash starts fetch at address 0000H.
// - Fetch past application flash returns NOP, increments up to 3FFFH, wraps to 0000H.
// - Loader flash execution remaps its first byte to 0000H; vectors stay usable.
// - Data flash start is base-high register as upper byte, lower byte zero.
// - After every reset the base-high register loads from the second configuration byte.
// - Writing base-high moves the boundary immediately; application flash adjusts to match.
// - Base-high writes without the timed-access unlock are ignored.
// - Small variant: data flash fixed at 3000H-3FFFH, base-high has no effect.
// - Large variant: enable bit left at one maps the whole 16K block as application flash.
// - Configuration bytes change only via parallel writer, IN_CIRCUIT_PROGRAMMING, or loader-resident code.
// - Opcode fetches come only from application or loader flash; on the large variant only, code reads can also reach data flash.
`timescale 1ns/100ps
module fmmp_flash_map #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Configuration bytes as read from the array
    input wire logic [7:0] config_byte_zero,
    input wire logic [7:0] config_byte_one,
    // Core control
    input wire logic boot_select,
    input wire logic ta_unlocked,
    input wire logic base_wr,
    input wire logic [7:0] base_wdata,
    // Fetch and code-read path
    input wire fmmp_pkg::fmmp_req_s req,
    output fmmp_pkg::fmmp_resp_s resp,
    // Erase and program requests
    input wire logic nvm_req,
    input wire logic nvm_erase,
    input wire logic nvm_config,
    input wire logic [1:0] nvm_agent,
    input wire logic [15:0] nvm_addr,
    output fmmp_pkg::fmmp_nvm_s nvm_cmd,
    output logic nvm_refused,
    // Status
    output logic [7:0] dataflash_base_high,
    output logic [15:0] dataflash_start,
    output logic dataflash_active
);

    typedef struct packed {
        logic loaded;
        logic [7:0] base;
        fmmp_pkg::fmmp_resp_s resp;
        fmmp_pkg::fmmp_nvm_s nvm;
        logic refused;
    } fmmp_state_s;

    fmmp_state_s st;
    fmmp_state_s next_st;
    logic dataflash_enable_cfg;
    logic [15:0] df_start;
    logic [15:0] app_limit;

    // Page alignment used for both bounds of an erase
    function automatic logic [15:0] fmmp_page_base(input logic [15:0] a);
        fmmp_page_base = a & fmmp_pkg::PAGE_MASK;
    endfunction

    // Boundary decode; the loader runs outside this 16K map
    assign dataflash_enable_cfg = ~config_byte_zero[fmmp_pkg::CFG_DATAFLASH_ENABLE_CFG_BIT];
    always_comb begin
        df_start = fmmp_pkg::FLASH_BYTES;
        if (!LARGE_VARIANT) begin
            df_start = fmmp_pkg::SMALL_DF_START;
        end else if (dataflash_enable_cfg) begin
            df_start = {st.base, fmmp_pkg::DF_BASE_LOW};
        end
    end
    // Small variant holds only 8K of application code below its data flash
    assign app_limit = LARGE_VARIANT ? df_start : fmmp_pkg::SMALL_APP_BYTES;

    // Next-state logic
    always_comb begin
        logic [15:0] pc;
        pc = req.addr;
        next_st = st;
        // Base register catches the configuration byte once after reset release
        if (!st.loaded) begin
            next_st.loaded = 1'b1;
            next_st.base = config_byte_one;
        end else if (base_wr && ta_unlocked) begin
            next_st.base = base_wdata;
        end
        // Fetch decode
        next_st.resp.valid = req.valid;
        next_st.resp.nop = 1'b0;
        next_st.resp.phys = pc;
        next_st.resp.next_pc = (pc >= fmmp_pkg::ADDR_TOP) ? fmmp_pkg::ADDR_ZERO
                                                         : 16'(pc + 16'h0001);
        if (boot_select) begin
            // Loader seen from 0000H so the vector table works unchanged
            next_st.resp.region = fmmp_pkg::FMMP_RGN_LOADER;
            next_st.resp.phys = pc & 16'(fmmp_pkg::LOADER_BYTES - 16'h0001);
            next_st.resp.nop = pc >= fmmp_pkg::LOADER_BYTES;
        end else if (pc < app_limit) begin
            next_st.resp.region = fmmp_pkg::FMMP_RGN_APP;
        end else if (LARGE_VARIANT && dataflash_enable_cfg && req.code_read &&
                     pc <= fmmp_pkg::ADDR_TOP) begin
            next_st.resp.region = fmmp_pkg::FMMP_RGN_DATA;
        end else begin
            // Instruction fetch never executes data flash or empty space
            next_st.resp.region = fmmp_pkg::FMMP_RGN_VOID;
            next_st.resp.nop = 1'b1;
        end
        // Erase and program commands
        // The whole command clears each cycle so a refused request never shows stale fields
        next_st.nvm = '0;
        next_st.refused = 1'b0;
        if (nvm_req) begin
            if (nvm_config && nvm_agent == fmmp_pkg::AGENT_CPU && !boot_select) begin
                next_st.refused = 1'b1;
            end else begin
                next_st.nvm.valid = 1'b1;
                next_st.nvm.erase = nvm_erase;
                next_st.nvm.config_target = nvm_config;
                next_st.nvm.first = nvm_erase ? fmmp_page_base(nvm_addr) : nvm_addr;
                next_st.nvm.last = nvm_erase
                    ? (fmmp_page_base(nvm_addr) | 16'((1 << fmmp_pkg::PAGE_BITS) - 1))
                    : nvm_addr;
            end
        end
    end

    // State register
    // Reset loads constants only; the configuration byte is caught on the first live edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.base <= fmmp_pkg::CFG_ERASED;
            st.resp.region <= fmmp_pkg::FMMP_RGN_APP;
        end else begin
            st <= next_st;
        end
    end

    assign resp = st.resp;
    assign nvm_cmd = st.nvm;
    assign nvm_refused = st.refused;
    assign dataflash_base_high = st.base;
    assign dataflash_start = df_start;
    assign dataflash_active = dataflash_enable_cfg || !LARGE_VARIANT;

    // Checks: each property watches what this block drives
    // Top address hands back 0000H as the next counter value
    AST_WRAP: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && req.addr == fmmp_pkg::ADDR_TOP |=> resp.next_pc == fmmp_pkg::ADDR_ZERO)
        else $error("pc did not wrap");

    // Counter never leaves the 16K map
    AST_NEXT_RANGE: assert property (@(posedge clk_sys) disable iff (rst)
        resp.valid |-> resp.next_pc <= fmmp_pkg::ADDR_TOP)
        else $error("next pc outside map");

    // Below the top the counter moves by exactly one
    AST_STEP: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && req.addr < fmmp_pkg::ADDR_TOP |=>
        resp.next_pc == 16'($past(req.addr) + 16'h0001))
        else $error("pc did not step by one");

    // Empty space only ever answers with the no-operation flag
    AST_VOID_NOP: assert property (@(posedge clk_sys) disable iff (rst)
        resp.valid && resp.region == fmmp_pkg::FMMP_RGN_VOID |-> resp.nop)
        else $error("void fetch not nop");

    // An opcode fetch past application flash never executes real bytes
    AST_FETCH_PAST: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && !req.code_read && !boot_select && req.addr >= app_limit |=> resp.nop)
        else $error("fetch past app not nop");

    // Loader byte zero appears at program address zero
    AST_LOADER: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && boot_select && req.addr == 16'h0000 |=>
        resp.region == fmmp_pkg::FMMP_RGN_LOADER && resp.phys == 16'h0000)
        else $error("loader not at zero");

    // Every loader byte keeps its offset, so the vector table lines up
    AST_LDR_PHYS: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && boot_select && req.addr < fmmp_pkg::LOADER_BYTES |=>
        resp.phys == $past(req.addr) && !resp.nop)
        else $error("loader offset moved");

    // Loader is only 2K; anything above it answers no-operation
    AST_LDR_NOP: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && boot_select && req.addr >= fmmp_pkg::LOADER_BYTES |=>
        resp.nop && resp.region == fmmp_pkg::FMMP_RGN_LOADER)
        else $error("loader overrun not nop");

    // Application boot starts at 0000H
    AST_BOOT0: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && !boot_select && req.addr == 16'h0000 && app_limit != 16'h0000 |=>
        resp.region == fmmp_pkg::FMMP_RGN_APP && !resp.nop)
        else $error("boot fetch not app");

    // Application addresses pass through untouched
    AST_APP_PHYS: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && !boot_select && req.addr < app_limit |=>
        resp.region == fmmp_pkg::FMMP_RGN_APP && resp.phys == $past(req.addr) && !resp.nop)
        else $error("app fetch misdecoded");

    // Every request gets exactly one answer, one cycle later
    AST_LIVE_FETCH: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid |=> resp.valid)
        else $error("fetch not answered");

    // No answer without a request
    AST_IDLE_FETCH: assert property (@(posedge clk_sys) disable iff (rst)
        !req.valid |=> !resp.valid)
        else $error("answer without fetch");

    // Start address is base byte over a zero low byte
    AST_START: assert property (@(posedge clk_sys) disable iff (rst)
        LARGE_VARIANT && dataflash_enable_cfg |->
        dataflash_start[7:0] == fmmp_pkg::DF_BASE_LOW &&
        dataflash_start[15:8] == dataflash_base_high)
        else $error("start address wrong");

    // Code reads at or above the start land in data flash
    AST_DATA: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && !boot_select && LARGE_VARIANT && dataflash_enable_cfg &&
        req.code_read && req.addr >= df_start && req.addr <= fmmp_pkg::ADDR_TOP |=>
        resp.region == fmmp_pkg::FMMP_RGN_DATA)
        else $error("data flash not decoded");

    // On the large variant application flash ends exactly where data flash begins
    AST_SHRINK: assert property (@(posedge clk_sys) disable iff (rst)
        LARGE_VARIANT |-> app_limit == dataflash_start)
        else $error("app and data flash overlap");

    // A locked register keeps its value
    AST_LOCK: assert property (@(posedge clk_sys) disable iff (rst)
        st.loaded && !(base_wr && ta_unlocked) |=> $stable(dataflash_base_high))
        else $error("base changed without unlock");

    // An unlocked write takes effect on the next edge
    AST_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
        st.loaded && base_wr && ta_unlocked |=> dataflash_base_high == $past(base_wdata))
        else $error("unlocked write lost");

    // First edge after reset copies the configuration base byte
    AST_LOAD: assert property (@(posedge clk_sys) disable iff (rst)
        !st.loaded |=> dataflash_base_high == $past(config_byte_one))
        else $error("base not loaded");

    // Small variant ignores the base register for the data flash start
    AST_SMALL_FIX: assert property (@(posedge clk_sys) disable iff (rst)
        !LARGE_VARIANT |-> dataflash_start == fmmp_pkg::SMALL_DF_START)
        else $error("small data flash moved");

    // Small variant holds no code above 8K
    AST_SMALL_APP: assert property (@(posedge clk_sys) disable iff (rst)
        !LARGE_VARIANT && req.valid && !boot_select &&
        req.addr >= fmmp_pkg::SMALL_APP_BYTES |=> resp.nop)
        else $error("small variant overrun");

    // An erase command covers one aligned page
    AST_PAGE: assert property (@(posedge clk_sys) disable iff (rst)
        nvm_cmd.valid && nvm_cmd.erase |->
        nvm_cmd.last - nvm_cmd.first == 16'h007f && nvm_cmd.first[6:0] == 7'h00)
        else $error("erase not one page");

    // The page erased is the one holding the requested address
    AST_ERASE_HIT: assert property (@(posedge clk_sys) disable iff (rst)
        nvm_req && nvm_erase && !(nvm_config && nvm_agent == fmmp_pkg::AGENT_CPU &&
        !boot_select) |=> nvm_cmd.valid &&
        nvm_cmd.first == ($past(nvm_addr) & fmmp_pkg::PAGE_MASK))
        else $error("wrong page erased");

    // Programming touches a single byte only
    AST_PROG_ONE: assert property (@(posedge clk_sys) disable iff (rst)
        nvm_cmd.valid && !nvm_cmd.erase |-> nvm_cmd.first == nvm_cmd.last)
        else $error("program spans bytes");

    // Application code may not change the configuration bytes
    AST_CFG: assert property (@(posedge clk_sys) disable iff (rst)
        nvm_req && nvm_config && nvm_agent == fmmp_pkg::AGENT_CPU && !boot_select |=>
        nvm_refused && !nvm_cmd.valid)
        else $error("config write allowed");

    // Writers and loader code are let through
    AST_CFG_OK: assert property (@(posedge clk_sys) disable iff (rst)
        nvm_req && nvm_config && (nvm_agent != fmmp_pkg::AGENT_CPU || boot_select) |=>
        nvm_cmd.valid && nvm_cmd.config_target && !nvm_refused)
        else $error("allowed config write refused");

    // No command and no refusal appear without a request
    AST_IDLE_NVM: assert property (@(posedge clk_sys) disable iff (rst)
        !nvm_req |=> !nvm_cmd.valid && !nvm_refused)
        else $error("spurious nvm command");

    // Erased enable bit gives the whole block to the application
    AST_WHOLE: assert property (@(posedge clk_sys) disable iff (rst)
        LARGE_VARIANT && !dataflash_enable_cfg |-> app_limit == fmmp_pkg::FLASH_BYTES)
        else $error("app flash not whole");

    // Status flag follows the erased enable bit
    AST_ACTIVE: assert property (@(posedge clk_sys) disable iff (rst)
        LARGE_VARIANT && config_byte_zero[fmmp_pkg::CFG_DATAFLASH_ENABLE_CFG_BIT] |-> !dataflash_active)
        else $error("data flash active while erased");
endmodule

// ---- design/fmmp_pkg.sv ----
// Package with constants and carrier types of the flash memory map and partition block
package fmmp_pkg;
    // Address space and region sizes
    localparam logic [15:0] ADDR_ZERO = 16'h0000;
    localparam logic [15:0] ADDR_TOP = 16'h3fff;
    localparam logic [15:0] FLASH_BYTES = 16'h4000;
    localparam logic [15:0] LOADER_BYTES = 16'h0800;
    localparam logic [15:0] SMALL_APP_BYTES = 16'h2000;
    localparam logic [15:0] SMALL_DF_START = 16'h3000;
    localparam logic [7:0] DF_BASE_LOW = 8'h00;
    localparam logic [7:0] NOP_OPCODE = 8'h00;
    // Page geometry: 128-byte pages, offset field is the low 7 bits
    localparam int PAGE_BITS = 7;
    localparam logic [15:0] PAGE_MASK = 16'hff80;
    // Configuration byte field positions
    localparam int CFG_DATAFLASH_ENABLE_CFG_BIT = 0;
    localparam logic [7:0] CFG_ERASED = 8'hff;
    // Programming agent codes
    localparam logic [1:0] AGENT_CPU = 2'h0;
    localparam logic [1:0] AGENT_PARALLEL = 2'h1;
    localparam logic [1:0] AGENT_ICP = 2'h2;

    // Region decode result
    typedef enum logic [3:0] {
        FMMP_RGN_APP = 4'h1,
        FMMP_RGN_DATA = 4'h2,
        FMMP_RGN_LOADER = 4'h4,
        FMMP_RGN_VOID = 4'h8
    } fmmp_region_e;

    // Fetch / code-read request from the core
    typedef struct packed {
        logic valid;
        logic code_read;
        logic [15:0] addr;
    } fmmp_req_s;

    // Decoded answer to the core
    typedef struct packed {
        logic valid;
        logic nop;
        fmmp_region_e region;
        logic [15:0] phys;
        logic [15:0] next_pc;
    } fmmp_resp_s;

    // Erase / program command toward the flash array
    typedef struct packed {
        logic valid;
        logic erase;
        logic [15:0] first;
        logic [15:0] last;
        logic config_target;
    } fmmp_nvm_s;
endpackage

// ---- testbench/fmmp_core_model.sv ----
// Core fetch model that drives the fetch and code-read request path
`timescale 1ns/100ps
module fmmp_core_model (
    // Clock
    input wire logic clk_sys,
    // Fetch path
    output fmmp_pkg::fmmp_req_s req,
    input wire fmmp_pkg::fmmp_resp_s resp
);
    initial begin
        req = '0;
    end
    // One fetch per call, answer taken one cycle after the request edge
    task automatic fetch(input logic [15:0] a, input logic cr, output fmmp_pkg::fmmp_resp_s r);
        @(negedge clk_sys);
        req = '{valid: 1'b1, code_read: cr, addr: a};
        @(negedge clk_sys);
        r = resp;
        // Idle address inverted so a stale value never looks like a live request
        req = '{valid: 1'b0, code_read: 1'b0, addr: ~a};
    endtask
endmodule

// ---- testbench/tb_fmmp_flash_map.sv ----
// Self-checking testbench for the flash memory map and partition block
`timescale 1ns/100ps
module tb_fmmp_flash_map;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] config_byte_zero = 8'hfe;
    logic [7:0] config_byte_one = 8'h30;
    logic boot_select = 1'b0;
    logic ta_unlocked = 1'b0;
    logic base_wr = 1'b0;
    logic [7:0] base_wdata = 8'h00;
    logic nvm_req = 1'b0;
    logic nvm_erase = 1'b0;
    logic nvm_config = 1'b0;
    logic [1:0] nvm_agent = 2'h0;
    logic [15:0] nvm_addr = 16'h0000;
    fmmp_pkg::fmmp_req_s req;
    fmmp_pkg::fmmp_resp_s resp;
    fmmp_pkg::fmmp_resp_s rsp;
    fmmp_pkg::fmmp_nvm_s nvm_cmd;
    logic nvm_refused;
    logic [7:0] dataflash_base_high;
    logic [15:0] dataflash_start;
    logic dataflash_active;
    fmmp_pkg::fmmp_resp_s resp_small;
    fmmp_pkg::fmmp_nvm_s nvm_cmd_small;
    logic nvm_refused_small;
    logic [7:0] base_small;
    logic [15:0] start_small;
    logic active_small;
    int n_errors = 0;
    int checks = 0;

    fmmp_flash_map #(.LARGE_VARIANT(1'b1)) i_dut (.clk_sys, .rst, .config_byte_zero,
        .config_byte_one, .boot_select, .ta_unlocked, .base_wr, .base_wdata, .req, .resp,
        .nvm_req, .nvm_erase, .nvm_config, .nvm_agent, .nvm_addr, .nvm_cmd, .nvm_refused,
        .dataflash_base_high, .dataflash_start, .dataflash_active);
    // Small variant shares every input and answers on its own outputs
    fmmp_flash_map #(.LARGE_VARIANT(1'b0)) i_dut_small (.clk_sys, .rst, .config_byte_zero,
        .config_byte_one, .boot_select, .ta_unlocked, .base_wr, .base_wdata, .req,
        .resp(resp_small), .nvm_req, .nvm_erase, .nvm_config, .nvm_agent, .nvm_addr,
        .nvm_cmd(nvm_cmd_small), .nvm_refused(nvm_refused_small),
        .dataflash_base_high(base_small), .dataflash_start(start_small),
        .dataflash_active(active_small));
    fmmp_core_model i_cpu (.clk_sys, .req, .resp);

    // 100 MHz system clock
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic close_out();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Ten cycles of reset, then two edges so base writes are honoured
    task automatic do_reset();
        rst = 1'b1;
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask

    // Expected word is {valid, nop, region}
    task automatic fx(input logic [15:0] a, input logic cr, input logic [5:0] e);
        i_cpu.fetch(a, cr, rsp);
        chk({rsp.valid, rsp.nop, rsp.region}, e);
    endtask

    task automatic wr_base(input logic ul, input logic [7:0] d);
        @(negedge clk_sys);
        {base_wr, ta_unlocked, base_wdata} = {1'b1, ul, d};
        @(negedge clk_sys);
        base_wr = 1'b0;
    endtask

    // Expected word is {refused, valid, erase, config_target}
    task automatic nv(input logic er, cf, input logic [1:0] ag, input logic [3:0] e);
        @(negedge clk_sys);
        {nvm_req, nvm_erase, nvm_config, nvm_agent, nvm_addr} = {1'b1, er, cf, ag, 16'h1234};
        @(negedge clk_sys);
        nvm_req = 1'b0;
        chk({nvm_refused, nvm_cmd.valid, nvm_cmd.erase, nvm_cmd.config_target}, e);
    endtask

    // Partition after reset and software moves of the boundary
    task automatic t_partition();
        config_byte_zero = 8'hfe;
        do_reset();
        chk(dataflash_base_high, 8'h30);
        chk(dataflash_start, 16'h3000);
        chk(dataflash_active, 1'b1);
        chk(active_small, 1'b1);
        fx(16'h2fff, 1'b1, 6'h21);
        chk({resp_small.valid, resp_small.nop, resp_small.region}, 6'h38);
        fx(16'h3000, 1'b1, 6'h22);
        wr_base(1'b0, 8'h20);
        chk(dataflash_base_high, 8'h30);
        wr_base(1'b1, 8'h20);
        chk(dataflash_start, 16'h2000);
        chk(start_small, 16'h3000);
        fx(16'h1fff, 1'b1, 6'h21);
        chk({resp_small.valid, resp_small.nop, resp_small.region}, 6'h21);
        fx(16'h2000, 1'b1, 6'h22);
        $display("test partition done");
    endtask

    // Boot fetch, wrap past application flash, loader remap
    task automatic t_fetch();
        fx(16'h0000, 1'b0, 6'h21);
        chk(rsp.phys, 16'h0000);
        fx(16'h2abc, 1'b0, 6'h38);
        chk(rsp.next_pc, 16'h2abd);
        fx(16'h3fff, 1'b0, 6'h38);
        chk(rsp.next_pc, 16'h0000);
        boot_select = 1'b1;
        fx(16'h0000, 1'b0, 6'h24);
        fx(16'h0003, 1'b0, 6'h24);
        chk(rsp.phys, 16'h0003);
        fx(16'h07ff, 1'b0, 6'h24);
        fx(16'h0800, 1'b0, 6'h34);
        boot_select = 1'b0;
        $display("test fetch done");
    endtask

    // Page erase range and who may touch configuration bytes
    task automatic t_nvm();
        nv(1'b1, 1'b0, 2'h0, 4'h6);
        chk({nvm_cmd.first, nvm_cmd.last}, 32'h1200_127f);
        nv(1'b1, 1'b1, 2'h0, 4'h8);
        nv(1'b0, 1'b1, 2'h1, 4'h5);
        nv(1'b1, 1'b1, 2'h2, 4'h7);
        boot_select = 1'b1;
        nv(1'b1, 1'b1, 2'h0, 4'h7);
        boot_select = 1'b0;
        $display("test nvm done");
    endtask

    // Enable bit left erased gives the whole block to the application
    task automatic t_dataflash_enable_cfg_off();
        config_byte_zero = 8'hff;
        do_reset();
        chk(dataflash_active, 1'b0);
        fx(16'h3fff, 1'b1, 6'h21);
        $display("test dataflash_enable_cfg_off done");
    endtask

    // Hang guard
    initial begin
        repeat (3000) @(posedge clk_sys);
        n_errors++;
        close_out();
    end

    initial begin
        t_partition();
        t_fetch();
        t_nvm();
        t_dataflash_enable_cfg_off();
        close_out();
    end
endmodule
